// ### inc/cmp_if.sv
// Purpose: carries compare operands to the flag unit and flags back
// Assumes: purely combinational path
// Notes:   lhs minus rhs, result itself is discarded
`timescale 1ns/1ps
interface cmp_if;
	logic [7:0] lhs;
	logic [7:0] rhs;
	logic [4:0] flags;

	modport unit (input lhs, input rhs, output flags);
	modport user (output lhs, output rhs, input flags);
endinterface : cmp_if

// ### inc/cse_pkg.sv
// Purpose: shared constants and types for the call, compare and skip executor
// Assumes: one core clock; operands arrive from the core's decode stage
// Notes:   flag vector order is {half, overflow, negative, zero, carry}
package cse_pkg;

	typedef enum logic [2:0] {
		pointer_call_op,
		equal_skip_op,
		immediate_compare_op,
		reg_bit_clear_skip_op,
		reg_bit_set_skip_op,
		io_bit_clear_skip_op
	} op_kind_t;

	localparam int          DATA_W        = 8;
	localparam int          PC_W          = 16;
	localparam int          FLAG_W        = 5;
	localparam int          BIT_SEL_W     = 3;

	// flag positions inside the flag vector
	localparam int          FLAG_C        = 0;
	localparam int          FLAG_Z        = 1;
	localparam int          FLAG_N        = 2;
	localparam int          FLAG_V        = 3;
	localparam int          FLAG_H        = 4;

	// operand bit positions used by the flag equations
	localparam int          SIGN_BIT      = 7;
	localparam int          NIBBLE_BIT    = 3;

	// cycle counts per instruction
	localparam logic [1:0]  CALL_CYCLES   = 2'h3;
	localparam logic [1:0]  CMP_CYCLES    = 2'h1;
	localparam logic [1:0]  NOSKIP_CYCLES = 2'h1;
	localparam logic [1:0]  SKIP1_CYCLES  = 2'h2;
	localparam logic [1:0]  SKIP2_CYCLES  = 2'h3;

	// program counter steps
	localparam logic [15:0] PC_STEP_NEXT  = 16'h0001;
	localparam logic [15:0] PC_STEP_SKIP1 = 16'h0002;
	localparam logic [15:0] PC_STEP_SKIP2 = 16'h0003;

	localparam logic [15:0] PC_RESET      = 16'h0000;
	localparam logic [4:0]  FLAGS_RESET   = 5'h00;

endpackage : cse_pkg

// ### tb/test_call_compare_skip_exec.sv
// Purpose: self-checking bench for the call, compare and skip executor
// Assumes: inputs change on the falling edge; one operation in flight at a time
// Notes:   expected compare flags and counts are derived here; kept flags are read back from the block before the op
`timescale 1ns/1ps
module test_call_compare_skip_exec;
	logic                       ref_clk_i;
	logic                       resetn_i;
	logic                       op_valid_i;
	logic                       op_ready_o;
	cse_pkg::op_kind_t          op_kind_i;
	logic [15:0]                pc_i;
	logic [15:0]                ptr_i;
	logic [7:0]                 reg_d_i;
	logic [7:0]                 reg_r_i;
	logic [7:0]                 imm_i;
	logic [7:0]                 io_val_i;
	logic [2:0]                 bit_sel_i;
	logic                       next_two_word_i;
	logic                       done_o;
	logic                       pc_load_o;
	logic [15:0]                pc_o;
	logic                       push_o;
	logic [15:0]                push_data_o;
	logic                       flags_we_o;
	logic [4:0]                 flags_o;
	int                         err_total;
	int                         tests_run;
	logic                       fw_seen;
	logic                       push_seen;
	int                         n;

	call_compare_skip_exec i_call_compare_skip_exec (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
		.op_valid_i(op_valid_i), .op_ready_o(op_ready_o), .op_kind_i(op_kind_i), .pc_i(pc_i),
		.ptr_i(ptr_i), .reg_d_i(reg_d_i), .reg_r_i(reg_r_i), .imm_i(imm_i), .io_val_i(io_val_i),
		.bit_sel_i(bit_sel_i), .next_two_word_i(next_two_word_i), .done_o(done_o),
		.pc_load_o(pc_load_o), .pc_o(pc_o), .push_o(push_o), .push_data_o(push_data_o),
		.flags_we_o(flags_we_o), .flags_o(flags_o));

	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run

	// issues one operation and counts cycles from the take edge to done
	task automatic do_op(input cse_pkg::op_kind_t k, input logic [15:0] pc, input logic [15:0] ptr,
		input logic [7:0] d, input logic [7:0] r, input logic [7:0] imm, input logic [7:0] io,
		input logic [2:0] sel, input logic tw);
		op_kind_i = k;
		pc_i = pc;
		ptr_i = ptr;
		reg_d_i = d;
		reg_r_i = r;
		imm_i = imm;
		io_val_i = io;
		bit_sel_i = sel;
		next_two_word_i = tw;
		op_valid_i = 1'b1;
		fw_seen = 1'b0;
		push_seen = 1'b0;
		@(negedge ref_clk_i);
		op_valid_i = 1'b0;
		n = 1;
		while (done_o !== 1'b1) begin
			fw_seen |= (flags_we_o === 1'b1);
			push_seen |= (push_o === 1'b1);
			if (n > 12) begin
				err_total++;
				$display("unexpected at %0t: no completion", $time);
				complete_run();
			end
			@(negedge ref_clk_i);
			n++;
		end
		fw_seen |= (flags_we_o === 1'b1);
		push_seen |= (push_o === 1'b1);
		check({15'h0000, pc_load_o}, 16'h0001, "pc load pulse");
		@(negedge ref_clk_i);
		check({15'h0000, done_o}, 16'h0000, "done is one cycle");
	endtask : do_op

	// subtract without storing; flags packed {H,V,N,Z,C}
	function automatic logic [4:0] cmp_flags(input logic [7:0] d, input logic [7:0] k);
		logic [7:0] res;
		logic [8:0] wide;
		logic       h;
		logic       v;
		res = d - k;
		// borrows and overflow from operand arithmetic, kept apart from the bit equations
		wide = {d[7], d} - {k[7], k};
		h = (d[3:0] < k[3:0]);
		v = wide[8] ^ wide[7];
		return {h, v, res[7], (res == 8'h00), (d < k)};
	endfunction : cmp_flags

	task automatic test_reset();
		check(pc_o, 16'h0000, "pc after reset");
		check(push_data_o, 16'h0000, "return after reset");
		check({11'h000, flags_o}, 16'h0000, "flags after reset");
		check({14'h0000, op_ready_o, done_o}, 16'h0002, "idle after reset");
		$display("test reset done");
	endtask : test_reset

	task automatic test_call();
		logic [4:0] f0;
		f0 = flags_o;
		do_op(cse_pkg::pointer_call_op, 16'h7FFF, 16'hABCD, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 1'b1);
		check(16'(n), 16'h0003, "call cycles");
		check(pc_o, 16'hABCD, "call target");
		check(push_data_o, 16'h8000, "return point");
		check({15'h0000, push_seen}, 16'h0001, "return saved");
		check({10'h000, fw_seen, flags_o}, {10'h000, 1'b0, f0}, "call flags kept");
		$display("test pointer call done");
	endtask : test_call

	task automatic test_compare();
		logic [15:0] pairs [6];
		logic [4:0]  ef;
		pairs = '{16'h1020, 16'h8001, 16'h7FFF, 16'h3333, 16'h0801, 16'h0080};
		foreach (pairs[i]) begin
			do_op(cse_pkg::immediate_compare_op, 16'h0100 + 16'(i), 16'h0000, pairs[i][15:8],
				8'hEE, pairs[i][7:0], 8'h00, 3'h0, 1'b1);
			check(16'(n), 16'h0001, "compare cycles");
			check({15'h0000, fw_seen}, 16'h0001, "compare writes flags");
			ef = cmp_flags(pairs[i][15:8], pairs[i][7:0]);
			check({11'h000, flags_o}, {11'h000, ef}, "compare flags");
			check(pc_o, 16'h0101 + 16'(i), "compare next pc");
		end
		$display("test immediate compare done");
	endtask : test_compare

	task automatic test_skips();
		cse_pkg::op_kind_t kinds [4];
		logic [7:0]        m;
		logic [7:0]        r;
		logic [7:0]        io;
		logic [7:0]        d;
		logic [4:0]        f0;
		logic [2:0]        s;
		int                exp_n;
		kinds = '{cse_pkg::equal_skip_op, cse_pkg::reg_bit_clear_skip_op,
			cse_pkg::reg_bit_set_skip_op, cse_pkg::io_bit_clear_skip_op};
		f0 = flags_o;
		for (int k = 0; k < 4; k++) begin
			for (int c = 0; c < 4; c++) begin
				// bit index wraps at 8 so the mask always matches the selected bit
				s = 3'(k * 2 + c);
				m = 8'h01 << s;
				d = 8'h5A;
				case (k)
					0: r = c[1] ? 8'h5A : 8'h5B;
					1: r = c[1] ? ~m : m;
					2: r = c[1] ? m : ~m;
					default: r = c[1] ? m : ~m;
				endcase
				io = (k == 3) ? ~r : r;
				do_op(kinds[k], 16'hFFFE, 16'h0000, d, r, 8'h00, io, s, c[0]);
				exp_n = c[1] ? (c[0] ? 3 : 2) : 1;
				check(16'(n), 16'(exp_n), "skip cycles");
				check(pc_o, 16'hFFFE + 16'(exp_n), "skip pc");
				check({10'h000, fw_seen, flags_o}, {10'h000, 1'b0, f0}, "skip flags kept");
			end
		end
		$display("test skips done");
	endtask : test_skips

	initial begin
		err_total = 0;
		tests_run = 0;
		resetn_i = 1'b0;
		op_valid_i = 1'b0;
		op_kind_i = cse_pkg::pointer_call_op;
		pc_i = 16'h0000;
		ptr_i = 16'h0000;
		reg_d_i = 8'h00;
		reg_r_i = 8'h00;
		imm_i = 8'h00;
		io_val_i = 8'h00;
		bit_sel_i = 3'h0;
		next_two_word_i = 1'b0;
		repeat (12) @(negedge ref_clk_i);
		resetn_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		test_reset();
		test_call();
		test_compare();
		test_skips();
		complete_run();
	end
endmodule : test_call_compare_skip_exec

// ### verilog/call_compare_skip_exec.sv
// Purpose: executes pointer call, compares and conditional skips
// Assumes: decode presents one operation with ready/valid on the core clock
// Notes:   results appear with done_o after the instruction's cycle count
`timescale 1ns/1ps

module call_compare_skip_exec (
	input  wire logic                                 ref_clk_i,
	input  wire logic                                 resetn_i,
	input  wire logic                                 op_valid_i,
	output logic                                      op_ready_o,
	input  wire cse_pkg::op_kind_t                    op_kind_i,
	input  wire logic [cse_pkg::PC_W-1:0]             pc_i,
	input  wire logic [cse_pkg::PC_W-1:0]             ptr_i,
	input  wire logic [cse_pkg::DATA_W-1:0]           reg_d_i,
	input  wire logic [cse_pkg::DATA_W-1:0]           reg_r_i,
	input  wire logic [cse_pkg::DATA_W-1:0]           imm_i,
	input  wire logic [cse_pkg::DATA_W-1:0]           io_val_i,
	input  wire logic [cse_pkg::BIT_SEL_W-1:0]        bit_sel_i,
	input  wire logic                                 next_two_word_i,
	output logic                                      done_o,
	output logic                                      pc_load_o,
	output logic [cse_pkg::PC_W-1:0]                  pc_o,
	output logic                                      push_o,
	output logic [cse_pkg::PC_W-1:0]                  push_data_o,
	output logic                                      flags_we_o,
	output logic [cse_pkg::FLAG_W-1:0]                flags_o
);
	typedef enum logic {st_idle, st_busy} state_t;

	logic                 rst_meta_q;
	logic                 rst_sync_q;
	logic                 rst_n;
	logic                 take;

	state_t               state_q,   state_d;
	logic [1:0]           left_q,    left_d;
	logic                 done_q,    done_d;
	logic                 pcld_q,    pcld_d;
	logic [15:0]          pc_q,      pc_d;
	logic                 push_q,    push_d;
	logic [15:0]          pdat_q,    pdat_d;
	logic                 fwe_q,     fwe_d;
	logic [4:0]           flags_q,   flags_d;
	logic                 pend_pcld_q, pend_pcld_d;
	logic                 pend_push_q, pend_push_d;
	logic                 pend_fwe_q,  pend_fwe_d;
	logic [15:0]          pend_pc_q,   pend_pc_d;

	logic [1:0]           cycles;
	logic [15:0]          target;
	logic                 skip;

	cmp_if cmp ();

	// true when the operation's condition asks for a skip
	function automatic logic skip_taken(
		input cse_pkg::op_kind_t kind,
		input logic [7:0]        d,
		input logic [7:0]        r,
		input logic [7:0]        io,
		input logic [2:0]        sel
	);
		logic res;
		res = 1'b0;
		unique case (kind)
			cse_pkg::equal_skip_op:         res = (d == r);
			cse_pkg::reg_bit_clear_skip_op: res = ~r[sel];
			cse_pkg::reg_bit_set_skip_op:   res = r[sel];
			cse_pkg::io_bit_clear_skip_op:  res = ~io[sel];
			default:                        res = 1'b0;
		endcase
		return res;
	endfunction : skip_taken

	// reset release is synchronised, assertion stays asynchronous
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	assign rst_n = rst_sync_q;

	assign cmp.lhs = reg_d_i;
	assign cmp.rhs = imm_i;

	cmp_flag_unit i_cmp_flag_unit (
		.cmp (cmp.unit)
	);

	assign op_ready_o = (state_q == st_idle);
	assign take       = op_valid_i && op_ready_o;

	always_comb begin
		skip   = skip_taken(op_kind_i, reg_d_i, reg_r_i, io_val_i, bit_sel_i);
		cycles = cse_pkg::NOSKIP_CYCLES;
		target = pc_i + cse_pkg::PC_STEP_NEXT;
		if (op_kind_i == cse_pkg::pointer_call_op) begin
			cycles = cse_pkg::CALL_CYCLES;
			target = ptr_i;
		end else if (op_kind_i == cse_pkg::immediate_compare_op) begin
			cycles = cse_pkg::CMP_CYCLES;
		end else if (skip && next_two_word_i) begin
			cycles = cse_pkg::SKIP2_CYCLES;
			target = pc_i + cse_pkg::PC_STEP_SKIP2;
		end else if (skip) begin
			cycles = cse_pkg::SKIP1_CYCLES;
			target = pc_i + cse_pkg::PC_STEP_SKIP1;
		end
	end

	always_comb begin
		state_d     = state_q;
		left_d      = left_q;
		done_d      = 1'b0;
		pcld_d      = 1'b0;
		push_d      = 1'b0;
		fwe_d       = 1'b0;
		pc_d        = pc_q;
		pdat_d      = pdat_q;
		flags_d     = flags_q;
		pend_pcld_d = pend_pcld_q;
		pend_push_d = pend_push_q;
		pend_fwe_d  = pend_fwe_q;
		pend_pc_d   = pend_pc_q;
		unique case (state_q)
			st_idle: begin
				if (take) begin
					pend_pc_d   = target;
					pend_pcld_d = 1'b1;
					pend_push_d = (op_kind_i == cse_pkg::pointer_call_op);
					pend_fwe_d  = (op_kind_i == cse_pkg::immediate_compare_op);
					if (op_kind_i == cse_pkg::pointer_call_op) begin
						pdat_d = pc_i + cse_pkg::PC_STEP_NEXT;
					end
					if (op_kind_i == cse_pkg::immediate_compare_op) begin
						flags_d = cmp.flags;
					end
					if (cycles == cse_pkg::NOSKIP_CYCLES) begin
						// single-cycle ops finish without leaving idle
						done_d = 1'b1;
						pcld_d = 1'b1;
						pc_d   = target;
						fwe_d  = (op_kind_i == cse_pkg::immediate_compare_op);
					end else begin
						state_d = st_busy;
						left_d  = cycles - 2'h1;
					end
				end
			end
			st_busy: begin
				left_d = left_q - 2'h1;
				if (left_q == 2'h1) begin
					state_d = st_idle;
					done_d  = 1'b1;
					pcld_d  = pend_pcld_q;
					push_d  = pend_push_q;
					fwe_d   = pend_fwe_q;
					pc_d    = pend_pc_q;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q     <= st_idle;
			left_q      <= 2'h0;
			done_q      <= 1'b0;
			pcld_q      <= 1'b0;
			push_q      <= 1'b0;
			fwe_q       <= 1'b0;
			pc_q        <= cse_pkg::PC_RESET;
			pdat_q      <= cse_pkg::PC_RESET;
			flags_q     <= cse_pkg::FLAGS_RESET;
			pend_pcld_q <= 1'b0;
			pend_push_q <= 1'b0;
			pend_fwe_q  <= 1'b0;
			pend_pc_q   <= cse_pkg::PC_RESET;
		end else begin
			state_q     <= state_d;
			left_q      <= left_d;
			done_q      <= done_d;
			pcld_q      <= pcld_d;
			push_q      <= push_d;
			fwe_q       <= fwe_d;
			pc_q        <= pc_d;
			pdat_q      <= pdat_d;
			flags_q     <= flags_d;
			pend_pcld_q <= pend_pcld_d;
			pend_push_q <= pend_push_d;
			pend_fwe_q  <= pend_fwe_d;
			pend_pc_q   <= pend_pc_d;
		end
	end

	assign done_o      = done_q;
	assign pc_load_o   = pcld_q;
	assign pc_o        = pc_q;
	assign push_o      = push_q;
	assign push_data_o = pdat_q;
	assign flags_we_o  = fwe_q;
	assign flags_o     = flags_q;

	a_call_three_cycles: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(take && op_kind_i == cse_pkg::pointer_call_op) |->
		##1 !done_o ##1 !done_o ##1 (done_o && push_o && !flags_we_o && pc_load_o
			&& pc_o == $past(ptr_i, 3)
			&& push_data_o == $past(pc_i, 3) + cse_pkg::PC_STEP_NEXT))
		else $error("pointer call did not complete correctly in three cycles");

	a_equal_skip_pc: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(take && op_kind_i == cse_pkg::equal_skip_op && reg_d_i != reg_r_i) |->
		##1 (done_o && !flags_we_o && pc_o == $past(pc_i) + cse_pkg::PC_STEP_NEXT))
		else $error("unequal compare-skip did not fall through");

	a_compare_flags: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(take && op_kind_i == cse_pkg::immediate_compare_op) |->
		##1 (done_o && flags_we_o
			&& flags_o[cse_pkg::FLAG_Z] == ($past(reg_d_i) == $past(imm_i))
			&& flags_o[cse_pkg::FLAG_C] == ($past(reg_d_i) < $past(imm_i))))
		else $error("immediate compare flags wrong");

	a_regclr_skip: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(take && op_kind_i == cse_pkg::reg_bit_clear_skip_op && !reg_r_i[bit_sel_i]
			&& !next_two_word_i) |->
		##1 !done_o ##1 (done_o && !flags_we_o
			&& pc_o == $past(pc_i, 2) + cse_pkg::PC_STEP_SKIP1))
		else $error("register bit clear skip wrong");

	a_regset_skip: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(take && op_kind_i == cse_pkg::reg_bit_set_skip_op && reg_r_i[bit_sel_i]
			&& next_two_word_i) |->
		##3 (done_o && !flags_we_o && pc_o == $past(pc_i, 3) + cse_pkg::PC_STEP_SKIP2))
		else $error("register bit set skip wrong");

	a_ioclr_skip: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(take && op_kind_i == cse_pkg::io_bit_clear_skip_op && io_val_i[bit_sel_i]) |->
		##1 (done_o && !flags_we_o && pc_o == $past(pc_i) + cse_pkg::PC_STEP_NEXT))
		else $error("io bit clear skip taken when bit set");

	a_skip_busy_len: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(take && op_kind_i != cse_pkg::pointer_call_op
			&& op_kind_i != cse_pkg::immediate_compare_op && skip && next_two_word_i) |->
		##1 !op_ready_o [*2] ##1 op_ready_o)
		else $error("two-word skip did not hold for three cycles");

	a_flags_only_cmp: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		flags_we_o |-> $past(take && op_kind_i == cse_pkg::immediate_compare_op))
		else $error("flags written by a non-compare operation");

endmodule : call_compare_skip_exec

// ### verilog/cmp_flag_unit.sv
// Purpose: subtract without storing and derive the arithmetic flags
// Assumes: operands are stable within the cycle
// Notes:   combinational; the caller registers the flags
`timescale 1ns/1ps
module cmp_flag_unit (
	cmp_if.unit cmp
);
	logic [7:0] diff;
	logic       a7;
	logic       b7;
	logic       r7;
	logic       a3;
	logic       b3;
	logic       r3;

	always_comb begin
		diff = cmp.lhs - cmp.rhs;
		a7   = cmp.lhs[cse_pkg::SIGN_BIT];
		b7   = cmp.rhs[cse_pkg::SIGN_BIT];
		r7   = diff[cse_pkg::SIGN_BIT];
		a3   = cmp.lhs[cse_pkg::NIBBLE_BIT];
		b3   = cmp.rhs[cse_pkg::NIBBLE_BIT];
		r3   = diff[cse_pkg::NIBBLE_BIT];
		cmp.flags                  = cse_pkg::FLAGS_RESET;
		cmp.flags[cse_pkg::FLAG_C] = (~a7 & b7) | (b7 & r7) | (r7 & ~a7);
		cmp.flags[cse_pkg::FLAG_Z] = (diff == 8'h00);
		cmp.flags[cse_pkg::FLAG_N] = r7;
		cmp.flags[cse_pkg::FLAG_V] = (a7 & ~b7 & ~r7) | (~a7 & b7 & r7);
		cmp.flags[cse_pkg::FLAG_H] = (~a3 & b3) | (b3 & r3) | (r3 & ~a3);
	end
endmodule : cmp_flag_unit
